//--- core/qdsu_pkg.sv
/*
 Constants for the quad converter serial update logic: pin order, word
 layout, code values and counts. Assumes no other package.
*/
package qdsu_pkg;
   localparam int WORD_BITS = 32;
   localparam int CNT_W = 6;
   localparam int CHAN = 4;
   localparam int CODE_W = 16;
   localparam int PINS = 6;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [CNT_W-1:0] CNT_LAST = 6'h1F;
   // Synchroniser pin indices
   localparam int PIN_FRAME = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_DIN = 2;
   localparam int PIN_LOAD = 3;
   localparam int PIN_CLEAR = 4;
   localparam int PIN_POR = 5;
   // Idle level of each pin while reset holds
   localparam logic [PINS-1:0] PIN_IDLE = 6'h1F;
   // Settling cycles before the power-up select is caught
   localparam logic [2:0] INIT_CYC = 3'h4;
   localparam logic [2:0] INIT_ONE = 3'h1;
   // Word layout
   localparam int CMD_HI = 27;
   localparam int CMD_LO = 24;
   localparam int ADDR_HI = 23;
   localparam int ADDR_LO = 20;
   localparam int DATA_HI = 19;
   localparam int DATA_LO = 4;
   localparam int CSEL_HI = 1;
   localparam int CSEL_LO = 0;
   localparam logic [3:0] CMD_WR_IN = 4'h0;
   localparam logic [3:0] CMD_WR_UPD = 4'h3;
   localparam logic [3:0] CMD_SET_CLR = 4'h5;
   localparam logic [3:0] ADDR_ALL = 4'hF;
   // Clear-code selections and code values
   localparam logic [1:0] CSEL_ZERO = 2'h0;
   localparam logic [1:0] CSEL_MID = 2'h1;
   localparam logic [1:0] CSEL_FULL = 2'h2;
   localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
   localparam logic [CODE_W-1:0] CODE_MID = 16'h8000;
   localparam logic [CODE_W-1:0] CODE_FULL = 16'hFFFF;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_WAIT = 3'b100
   } qdsu_state_t;
endpackage

//--- core/qdsu_sync.sv
/*
 Three-stage pin synchroniser with agreement filter and edge pulses.
 Assumes pins are asynchronous to clock; reset is synchronous, active low.
*/
`timescale 1ns/10ps
module qdsu_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Raw pins
   input wire logic [qdsu_pkg::PINS-1:0] pin_in,
   // Filtered levels and one-cycle edge pulses
   output logic [qdsu_pkg::PINS-1:0] level_r,
   output logic [qdsu_pkg::PINS-1:0] fall_r,
   output logic [qdsu_pkg::PINS-1:0] rise_r
);
   genvar i;
   generate
      for (i = 0; i < qdsu_pkg::PINS; i++) begin : g_pin
         logic s1_r, s2_r, s3_r;
         wire lvl_nxt = (s2_r == s3_r) ? s3_r : level_r[i];
         always_ff @(posedge clock) begin
            if (!nrst) begin
               s1_r <= qdsu_pkg::PIN_IDLE[i];
               s2_r <= qdsu_pkg::PIN_IDLE[i];
               s3_r <= qdsu_pkg::PIN_IDLE[i];
               level_r[i] <= qdsu_pkg::PIN_IDLE[i];
               fall_r[i] <= 1'b0;
               rise_r[i] <= 1'b0;
            end else begin
               s1_r <= pin_in[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               level_r[i] <= lvl_nxt;
               fall_r[i] <= level_r[i] & ~lvl_nxt;
               rise_r[i] <= ~level_r[i] & lvl_nxt;
            end
         end
      end
   endgenerate
endmodule

//--- core/qdsu_core.sv
/*
 Serial update logic of a quad voltage-output converter: three-wire link
 into a 32-bit shift register, input and output registers per channel,
 load strobe, edge-triggered clear and power-up code select.
 Assumes all pins are asynchronous to clock and the link clock is at least
 several times slower than clock; reset is synchronous, active low.
*/
// Summary of operation
// [R01] Frame select fall arms the shift register
// [R02] Shift one bit on next 32 falls
// [R03] Early frame rise aborts, registers unchanged
// [R04] Shift register 32 bits, samples on fall
// [R05] Load strobe low copies pending channels together
// [R06] Load strobe may stay low permanently
// [R07] Clear acts on its falling edge only
// [R08] Clear low blocks all load transfers
// [R09] Clear loads both levels with clear code
// [R10] Clear code defaults to zero after reset
// [R11] Power-up select picks zero or midscale
// [R12] Host keeps link clock at most 50 MHz
// [R13] Word acts after 32nd fall; refall needed
// [R14] Power-up value holds until write or clear
`timescale 1ns/10ps
module qdsu_core (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Serial link
   input wire logic frame_n,
   input wire logic sclk,
   input wire logic din,
   // Control pins
   input wire logic load_strobe_n,
   input wire logic clear_n,
   input wire logic por_sel,
   // Channel codes and pending flags
   output logic [qdsu_pkg::CHAN-1:0][qdsu_pkg::CODE_W-1:0] dac_code_r,
   output logic [qdsu_pkg::CHAN-1:0][qdsu_pkg::CODE_W-1:0] in_code_r,
   output logic [qdsu_pkg::CHAN-1:0] pending_r,
   // Status
   output logic link_armed,
   output logic word_done_r,
   output logic frame_abort_r
);
   logic [qdsu_pkg::PINS-1:0] lvl, fall, rise;
   qdsu_pkg::qdsu_state_t state_r, state_nxt;
   logic [qdsu_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [qdsu_pkg::WORD_BITS-1:0] shreg_r;
   logic [1:0] clr_sel_r;
   logic [2:0] init_cnt_r;
   logic init_done_r;

   qdsu_sync u_sync (
      .clock(clock),
      .nrst(nrst),
      .pin_in({por_sel, clear_n, load_strobe_n, din, sclk, frame_n}),
      .level_r(lvl),
      .fall_r(fall),
      .rise_r(rise)
   );

   wire frame_fall = fall[qdsu_pkg::PIN_FRAME];
   wire frame_rise = rise[qdsu_pkg::PIN_FRAME];
   wire frame_high = lvl[qdsu_pkg::PIN_FRAME];
   wire sclk_fall = fall[qdsu_pkg::PIN_SCLK];
   wire din_lvl = lvl[qdsu_pkg::PIN_DIN];
   wire clear_low = ~lvl[qdsu_pkg::PIN_CLEAR];
   wire clear_fall = fall[qdsu_pkg::PIN_CLEAR];
   wire por_lvl = lvl[qdsu_pkg::PIN_POR];
   wire in_shift = (state_r == qdsu_pkg::ST_SHIFT);
   wire bit_take = in_shift & sclk_fall;
   wire word_end = bit_take & (cnt_r == qdsu_pkg::CNT_LAST);
   // Abort only counts before the last bit has been taken
   wire abort = in_shift & frame_rise & ~word_end;
   wire [qdsu_pkg::WORD_BITS-1:0] word = {shreg_r[qdsu_pkg::WORD_BITS-2:0], din_lvl};
   wire [3:0] cmd = word[qdsu_pkg::CMD_HI:qdsu_pkg::CMD_LO];
   wire [3:0] addr = word[qdsu_pkg::ADDR_HI:qdsu_pkg::ADDR_LO];
   wire [qdsu_pkg::CODE_W-1:0] wdata = word[qdsu_pkg::DATA_HI:qdsu_pkg::DATA_LO];
   wire [1:0] csel = word[qdsu_pkg::CSEL_HI:qdsu_pkg::CSEL_LO];
   wire wr_in = word_end & ((cmd == qdsu_pkg::CMD_WR_IN) | (cmd == qdsu_pkg::CMD_WR_UPD));
   wire wr_upd = word_end & (cmd == qdsu_pkg::CMD_WR_UPD);
   wire set_clr = word_end & (cmd == qdsu_pkg::CMD_SET_CLR) & (csel != 2'h3);
   wire init_take = ~init_done_r & (init_cnt_r == qdsu_pkg::INIT_CYC);
   wire [qdsu_pkg::CODE_W-1:0] por_code = por_lvl ? qdsu_pkg::CODE_MID : qdsu_pkg::CODE_ZERO;
   wire [qdsu_pkg::CODE_W-1:0] clr_code =
      (clr_sel_r == qdsu_pkg::CSEL_MID) ? qdsu_pkg::CODE_MID :
      (clr_sel_r == qdsu_pkg::CSEL_FULL) ? qdsu_pkg::CODE_FULL : qdsu_pkg::CODE_ZERO;
   // Level sense so a strobe tied low keeps updating
   wire load_go = ~lvl[qdsu_pkg::PIN_LOAD] & ~clear_low; // [R05] [R06] [R08]

   assign link_armed = in_shift; // [R01]

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         qdsu_pkg::ST_IDLE: begin
            // Frames are ignored until the power-up code is in place
            if (frame_fall && init_done_r) begin // [R01] [R13]
               state_nxt = qdsu_pkg::ST_SHIFT;
               cnt_nxt = qdsu_pkg::CNT_ZERO;
            end
         end
         qdsu_pkg::ST_SHIFT: begin
            if (word_end) begin // [R13]
               state_nxt = qdsu_pkg::ST_WAIT;
            end else if (abort) begin // [R03]
               state_nxt = qdsu_pkg::ST_IDLE;
            end else if (bit_take) begin // [R02]
               cnt_nxt = cnt_r + qdsu_pkg::CNT_ONE;
            end
         end
         qdsu_pkg::ST_WAIT: begin
            if (frame_high) begin // [R13]
               state_nxt = qdsu_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = qdsu_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_r <= qdsu_pkg::ST_IDLE;
         cnt_r <= qdsu_pkg::CNT_ZERO;
         shreg_r <= '0;
         word_done_r <= 1'b0;
         frame_abort_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         if (bit_take) begin
            shreg_r <= word; // [R04]
         end
         word_done_r <= word_end;
         frame_abort_r <= abort;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         init_cnt_r <= '0;
         init_done_r <= 1'b0;
         clr_sel_r <= qdsu_pkg::CSEL_ZERO; // [R10]
      end else begin
         if (!init_done_r) begin
            init_cnt_r <= init_cnt_r + qdsu_pkg::INIT_ONE;
         end
         if (init_take) begin
            init_done_r <= 1'b1;
         end
         if (set_clr) begin
            clr_sel_r <= csel;
         end
      end
   end

   genvar c;
   generate
      for (c = 0; c < qdsu_pkg::CHAN; c++) begin : g_chan
         wire hit = (addr == qdsu_pkg::ADDR_ALL) || (addr == 4'(c));
         always_ff @(posedge clock) begin
            if (!nrst) begin
               in_code_r[c] <= qdsu_pkg::CODE_ZERO;
               dac_code_r[c] <= qdsu_pkg::CODE_ZERO;
               pending_r[c] <= 1'b0;
            end else if (init_take) begin
               in_code_r[c] <= por_code; // [R11]
               dac_code_r[c] <= por_code; // [R11]
               pending_r[c] <= 1'b0;
            end else if (clear_fall) begin
               // Edge only: a clear held low fires once
               in_code_r[c] <= clr_code; // [R07] [R09]
               dac_code_r[c] <= clr_code; // [R09]
               pending_r[c] <= 1'b0;
            end else if (wr_in && hit) begin
               // Power-up code stays until a complete write word for this channel arrives or clear falls
               in_code_r[c] <= wdata; // [R14]
               if (wr_upd && !clear_low) begin
                  dac_code_r[c] <= wdata;
                  pending_r[c] <= 1'b0;
               end else begin
                  pending_r[c] <= 1'b1;
               end
            end else if (load_go && pending_r[c]) begin
               dac_code_r[c] <= in_code_r[c]; // [R05]
               pending_r[c] <= 1'b0;
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence seq_last_bit;
      in_shift && sclk_fall && cnt_r == qdsu_pkg::CNT_LAST;
   endsequence
   sequence seq_early_rise;
      in_shift && frame_rise && !(sclk_fall && cnt_r == qdsu_pkg::CNT_LAST);
   endsequence

   AST_ARM: assert property (state_r == qdsu_pkg::ST_IDLE && frame_fall && init_done_r // [R01]
      |=> in_shift && cnt_r == qdsu_pkg::CNT_ZERO) else $error("frame not armed");
   AST_COUNT: assert property (in_shift && sclk_fall && cnt_r != qdsu_pkg::CNT_LAST // [R02]
      && !frame_rise |=> cnt_r == $past(cnt_r) + qdsu_pkg::CNT_ONE)
      else $error("bit count did not advance");
   AST_SHIFT: assert property (bit_take |=> shreg_r[0] == $past(din_lvl) // [R04]
      && shreg_r[qdsu_pkg::WORD_BITS-1:1] == $past(shreg_r[qdsu_pkg::WORD_BITS-2:0]))
      else $error("shift register did not take data");
   AST_ABORT: assert property (seq_early_rise and (!clear_fall && !load_go) // [R03]
      |=> state_r == qdsu_pkg::ST_IDLE && $stable(in_code_r) && $stable(dac_code_r)
      && !word_done_r) else $error("aborted frame changed state");
   AST_DONE: assert property (seq_last_bit |=> word_done_r // [R13]
      && state_r == qdsu_pkg::ST_WAIT ##1 !word_done_r) else $error("word end missed");
   AST_LOAD: assert property (init_done_r && pending_r[0] && load_go && !clear_fall // [R05]
      && !(wr_in && g_chan[0].hit) |=> dac_code_r[0] == $past(in_code_r[0]) && !pending_r[0])
      else $error("load strobe did not update channel");
   AST_CLRHOLD: assert property (init_done_r && clear_low && !clear_fall // [R08]
      |=> $stable(dac_code_r)) else $error("transfer while clear low");
   AST_CLR: assert property (init_done_r && clear_fall |=> in_code_r[1] == $past(clr_code) // [R09]
      && dac_code_r[1] == $past(clr_code) && pending_r == '0) else $error("clear code not loaded");
   AST_CLRDEF: assert property (!init_done_r |-> clr_sel_r == qdsu_pkg::CSEL_ZERO) // [R10]
      else $error("clear code not zero after reset");
   AST_POR: assert property (init_take |=> dac_code_r[2] == ($past(por_lvl) ? // [R11]
      qdsu_pkg::CODE_MID : qdsu_pkg::CODE_ZERO) && init_done_r) else $error("bad power-up code");
endmodule

//--- testbench/qdsu_host.sv
/*
 Host serial port model driving the three-wire link of the converter.
 Assumes the caller waits for a send to finish before starting another.
*/
`timescale 1ns/10ps
module qdsu_host (
   // Link pins
   output logic frame_n,
   output logic sclk,
   output logic din
);
   initial begin
      frame_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   // Sends n bits MSB first; fewer than 32 makes an early frame rise
   task automatic send(input logic [31:0] w, input int n);
      frame_n = 1'b0;
      #62.5;
      for (int i = 31; i > 31 - n; i--) begin
         din = w[i];
         #31.25 sclk = 1'b0;
         #62.5 sclk = 1'b1;
         #31.25;
      end
      // Released data line shows no stale value
      din = ~din;
      frame_n = 1'b1;
      #1000;
   endtask
endmodule

//--- testbench/qdsu_core_test.sv
/*
 Self-checking bench of the serial update logic against a register model.
 Assumes the host model and the core package are compiled first.
*/
`timescale 1ns/10ps
module qdsu_core_test;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic load_strobe_n = 1'b1;
   logic clear_n = 1'b1;
   logic por_sel;
   logic frame_n, sclk, din, link_armed, word_done_r, frame_abort_r;
   logic [3:0][15:0] dac_code_r, in_code_r;
   logic [3:0] pending_r, pend_m;
   logic [15:0] in_m [4];
   logic [15:0] dac_m [4];
   logic [1:0] csel_m = 2'h0;
   int err_count = 0, tests_run = 0, done_cnt = 0, abort_cnt = 0, done_m = 0, abort_m = 0;
   int arm_cnt = 0, arm_m = 0;
   logic arm_q = 1'b0;
   always #4 clock = ~clock;
   qdsu_host host (.frame_n(frame_n), .sclk(sclk), .din(din));
   qdsu_core uut (.clock(clock), .nrst(nrst), .frame_n(frame_n), .sclk(sclk), .din(din),
      .load_strobe_n(load_strobe_n), .clear_n(clear_n), .por_sel(por_sel),
      .dac_code_r(dac_code_r), .in_code_r(in_code_r), .pending_r(pending_r),
      .link_armed(link_armed), .word_done_r(word_done_r), .frame_abort_r(frame_abort_r));
   always @(posedge clock) begin
      if (word_done_r === 1'b1) done_cnt++;
      if (frame_abort_r === 1'b1) abort_cnt++;
      // Each frame must arm the link exactly once
      if (link_armed === 1'b1 && arm_q !== 1'b1) arm_cnt++;
      arm_q <= link_armed;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_all;
      for (int c = 0; c < 4; c++) begin
         cmp(in_code_r[c], in_m[c]);
         cmp(dac_code_r[c], dac_m[c]);
         cmp({15'h0000, pending_r[c]}, {15'h0000, pend_m[c]});
      end
      cmp(16'(done_cnt), 16'(done_m));
      cmp(16'(abort_cnt), 16'(abort_m));
      cmp(16'(arm_cnt), 16'(arm_m));
   endtask
   // Model of the load transfer, blocked while clear is low
   task automatic settle;
      if (load_strobe_n === 1'b0 && clear_n === 1'b1) begin
         for (int c = 0; c < 4; c++) begin
            if (pend_m[c]) begin
               dac_m[c] = in_m[c];
               pend_m[c] = 1'b0;
            end
         end
      end
   endtask
   task automatic wr(input logic [3:0] cmd, input logic [3:0] a, input int n);
      logic [15:0] d;
      d = 16'($urandom);
      host.send({4'h0, cmd, a, d, 2'h0, csel_m}, n);
      arm_m++;
      if (n < 32) abort_m++;
      else begin
         done_m++;
         for (int c = 0; c < 4; c++) begin
            if ((cmd == qdsu_pkg::CMD_WR_IN || cmd == qdsu_pkg::CMD_WR_UPD)
                  && (a == 4'(c) || a == qdsu_pkg::ADDR_ALL)) begin
               in_m[c] = d;
               pend_m[c] = 1'b1;
               if (cmd == qdsu_pkg::CMD_WR_UPD && clear_n === 1'b1) begin
                  dac_m[c] = d;
                  pend_m[c] = 1'b0;
               end
            end
         end
      end
      settle();
      step(2);
   endtask
   task automatic pulse_load;
      load_strobe_n = 1'b0;
      settle();
      step(6);
      load_strobe_n = 1'b1;
      step(10);
   endtask
   task automatic clr_edge;
      logic [15:0] v;
      v = (csel_m == qdsu_pkg::CSEL_MID) ? qdsu_pkg::CODE_MID :
         (csel_m == qdsu_pkg::CSEL_FULL) ? qdsu_pkg::CODE_FULL : qdsu_pkg::CODE_ZERO;
      clear_n = 1'b0;
      for (int c = 0; c < 4; c++) begin
         in_m[c] = v;
         dac_m[c] = v;
      end
      pend_m = 4'h0;
      step(10);
   endtask
   task automatic conclude;
      $display("tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h67d7));
      por_sel = 1'($urandom);
      step(10);
      nrst = 1'b1;
      step(20);
      for (int c = 0; c < 4; c++) begin
         in_m[c] = por_sel ? qdsu_pkg::CODE_MID : qdsu_pkg::CODE_ZERO;
         dac_m[c] = in_m[c];
      end
      pend_m = 4'h0;
      check_all();
      $display("test power-up done");
      clr_edge();
      check_all();
      clear_n = 1'b1;
      step(10);
      wr(qdsu_pkg::CMD_WR_IN, 4'h1, 32);
      check_all();
      pulse_load();
      check_all();
      wr(qdsu_pkg::CMD_WR_IN, 4'h2, 20);
      check_all();
      wr(qdsu_pkg::CMD_WR_UPD, 4'h2, 32);
      check_all();
      $display("test write, load and abort done");
      for (int s = 0; s < 3; s++) begin
         wr(qdsu_pkg::CMD_WR_IN, qdsu_pkg::ADDR_ALL, 32);
         csel_m = 2'(s);
         wr(qdsu_pkg::CMD_SET_CLR, 4'h0, 32);
         clr_edge();
         check_all();
         wr(qdsu_pkg::CMD_WR_IN, 4'h0, 32);
         pulse_load();
         check_all();
         clear_n = 1'b1;
         step(10);
         check_all();
      end
      $display("test clear codes done");
      load_strobe_n = 1'b0;
      settle();
      step(10);
      wr(qdsu_pkg::CMD_WR_IN, 4'h3, 32);
      check_all();
      $display("test tied load done");
      conclude();
   end
   initial begin
      #400000;
      err_count++;
      conclude();
   end
endmodule
